// [core/sdadc_regs.vh]
/*
  Register offsets, field positions, reset values and timing constants
  for the delta-sigma converter control block.
  Assumes an 8-bit register port with byte-wide offsets.
*/
`ifndef SDADC_REGS_VH
`define SDADC_REGS_VH

// ==========================================================
// register offsets
`define OFF_POWER_CONTROL   8'h00
`define OFF_CONV_CONTROL_0  8'h01
`define OFF_CONV_CONTROL_1  8'h02
`define OFF_AMP_CONTROL_0   8'h03
`define OFF_AMP_CONTROL_1   8'h04
`define OFF_AMP_CHANNEL     8'h05
`define OFF_RESULT_LOW      8'h06
`define OFF_RESULT_MIDDLE   8'h07
`define OFF_RESULT_HIGH     8'h08

// ==========================================================
// reset values
`define RST_POWER_CONTROL   8'h00
`define RST_CONV_CONTROL_0  8'h80
`define RST_CONV_CONTROL_1  8'h00
`define RST_AMP_CONTROL_0   8'h00
`define RST_AMP_CONTROL_1   8'h00
`define RST_AMP_CHANNEL     8'h00
`define RST_RESULT          24'h000000

// ==========================================================
// power control fields
`define PC_REG_EN     7
`define PC_REG_BYPASS 6
`define PC_VOUT_SEL   1
`define PC_VCM_EN     0

// conversion control 0 fields
`define C0_POWER_DOWN 7
`define C0_CONV_RESET 5
`define C0_REF_SEL    3
`define C0_RATE_HI    2
`define C0_RATE_LO    0

// conversion control 1 fields
`define C1_HOLD       7
`define C1_DONE       6
`define C1_INT_EN     5
`define C1_REQ        4
`define C1_FILT_HI    2
`define C1_FILT_LO    0

// amplifier control 0 fields
`define A0_AMP_HI     2
`define A0_AMP_LO     0
`define A0_CONV_HI    4
`define A0_CONV_LO    3
`define A0_REF_HI     6
`define A0_REF_LO     5

// amplifier control 1 fields
`define A1_POS_BUF    7
`define A1_NEG_BUF    6
`define A1_TRIM_HI    5
`define A1_TRIM_LO    0

// channel select fields and temperature sensor codes
`define CH_POS_HI     2
`define CH_POS_LO     0
`define CH_NEG_HI     5
`define CH_NEG_LO     3
`define CH_TEMP_POS   3'h6
`define CH_TEMP_NEG   3'h7

// ==========================================================
// result full scale
`define FS_POS        24'h7fffff
`define FS_NEG        24'h800000
`define FS_POS_WIDE   32'h007fffff
`define FS_NEG_WIDE   32'hff800000

// base conversion period in cycles at rate code zero
`define CONV_BASE_CYCLES 16'h0040

`endif

// [core/sdadc_saturate.v]
/*
  Clamps the wide signed filter output to the 24-bit result range.
  Assumes the filter output is already scaled so that one step equals
  the amplified reference divided by two to the twenty-third.
*/
`include "sdadc_regs.vh"

module sdadc_saturate
(
  input  wire [31:0] sample_in,
  output reg  [23:0] code_out
);

  // ========================================================
  // clamp against both full-scale limits
  always @*
  begin
    if (!sample_in[31] && (sample_in > `FS_POS_WIDE))
    begin
      code_out = `FS_POS;
    end
    else if (sample_in[31] && (sample_in < `FS_NEG_WIDE))
    begin
      code_out = `FS_NEG;
    end
    else
    begin
      code_out = sample_in[23:0];
    end
  end

endmodule // sdadc_saturate

// [core/sdadc_ctrl.v]
/*
  Control, timing and result handling for a 24-bit delta-sigma converter.
  Assumes a synchronous 8-bit register port and an analog front end with
  a decimation filter that presents a wide signed sample on FE_SAMPLE.
*/
// Added by the designer: the plain strobed port and the register addresses.
// How it works
// - setting the power-down bit gates off every converter enable and stops conversion.
// - each result is a 24-bit two's complement code whose top bit is the sign.
// - results beyond full scale clamp to 8388607 or -8388608 without wrapping.
// - one code step equals the amplified reference over 8388608, set by the front-end scaling.
// - the reference-select bit picks the external reference pins, else the internal supply.
// - amplifier, converter and reference gains come from three independent fields.
// - all-zero amplifier control registers mean unity gains and default input and offset.
// - routing the temperature sensor outputs to the amplifier converts the sensor.
// - a 3-bit rate field with a 3-bit filter mode field sets the output data rate.
// - the result reads as low, middle and high bytes with the sign in the high byte.
// - writing 10000011 to power control enables regulator and common mode at 3.3V.
// - each finished conversion sets the done flag and the interrupt request flag.
// - while hold is set the latest result is kept and newer ones are discarded.
`include "sdadc_regs.vh"

module sdadc_ctrl
#(
  parameter CONV_BASE = `CONV_BASE_CYCLES
)
(
  input  wire        CLK,
  input  wire        RST,
  input  wire [7:0]  ADDR,
  input  wire [7:0]  WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [7:0]  RDATA,
  input  wire [31:0] FE_SAMPLE,
  output wire        REG_EN,
  output wire        REG_BYPASS,
  output wire        REG_VOUT_SEL,
  output wire        VCM_EN,
  output wire        AMP_EN,
  output wire        CONV_EN,
  output wire        FILTER_EN,
  output wire        FILTER_CLEAR,
  output wire [2:0]  FILTER_MODE,
  output wire        REF_EXT_SEL,
  output wire [2:0]  AMP_GAIN,
  output wire [1:0]  CONV_GAIN,
  output wire [1:0]  REF_GAIN,
  output wire [5:0]  OFFSET_TRIM,
  output wire [2:0]  AMP_POS_SEL,
  output wire [2:0]  AMP_NEG_SEL,
  output wire        TEMP_SENSE_EN,
  output wire        POS_REF_BUF_EN,
  output wire        NEG_REF_BUF_EN,
  output wire        CONV_DONE,
  output wire        CONV_IRQ
);

  // ========================================================
  // conversion period from rate and filter mode
  function [15:0] conv_period;
    input [15:0] base;
    input [2:0]  rate;
    input [2:0]  filt;
    reg   [15:0] p;
    begin
      p = base << rate;
      // higher filter orders settle over a doubled window
      if (filt != 3'h0)
      begin
        p = p << 1;
      end
      conv_period = p;
    end
  endfunction

  // register write decode shared by every register
  function wr_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] off;
    begin
      wr_hit = wr && (addr == off);
    end
  endfunction

  // ========================================================
  // storage
  reg  [7:0]  power_control_reg;
  reg  [7:0]  conv_control_0_reg;
  reg  [7:0]  conv_control_1_reg;
  reg  [7:0]  amp_control_0_reg;
  reg  [7:0]  amp_control_1_reg;
  reg  [7:0]  amp_channel_reg;
  reg  [23:0] result_reg;
  reg  [23:0] result_next;
  reg         done_reg;
  reg         done_next;
  reg         req_reg;
  reg         req_next;
  reg         armed_reg;
  reg         armed_next;
  reg  [15:0] cnt_reg;
  reg  [15:0] cnt_next;
  reg  [7:0]  rdata_next;

  wire        power_down;
  wire        conv_reset;
  wire        running;
  wire        conv_end;
  wire [15:0] period;
  wire [23:0] sat_code;
  wire        wr_c1;
  wire        pos_temp;
  wire        neg_temp;

  assign power_down = conv_control_0_reg[`C0_POWER_DOWN];
  assign conv_reset = conv_control_0_reg[`C0_CONV_RESET];
  assign wr_c1      = wr_hit(WR, ADDR, `OFF_CONV_CONTROL_1);

  // ========================================================
  // clamp of the filter sample
  // clamp to full scale
  sdadc_saturate u_sat
  (
    .sample_in (FE_SAMPLE),
    .code_out  (sat_code)
  );

  // ========================================================
  // software-written control registers
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      power_control_reg  <= `RST_POWER_CONTROL;
      conv_control_0_reg <= `RST_CONV_CONTROL_0;
      amp_control_0_reg  <= `RST_AMP_CONTROL_0;
      amp_control_1_reg  <= `RST_AMP_CONTROL_1;
      amp_channel_reg    <= `RST_AMP_CHANNEL;
    end
    else
    begin
      if (wr_hit(WR, ADDR, `OFF_POWER_CONTROL))
      begin
        power_control_reg <= WDATA;
      end
      if (wr_hit(WR, ADDR, `OFF_CONV_CONTROL_0))
      begin
        conv_control_0_reg <= WDATA;
      end
      if (wr_hit(WR, ADDR, `OFF_AMP_CONTROL_0))
      begin
        amp_control_0_reg <= WDATA;
      end
      if (wr_hit(WR, ADDR, `OFF_AMP_CONTROL_1))
      begin
        amp_control_1_reg <= WDATA;
      end
      if (wr_hit(WR, ADDR, `OFF_AMP_CHANNEL))
      begin
        amp_channel_reg <= WDATA;
      end
    end
  end

  // control 1 holds software bits; the flag bits live apart
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      conv_control_1_reg <= `RST_CONV_CONTROL_1;
    end
    else if (wr_c1)
    begin
      conv_control_1_reg <= WDATA;
    end
  end

  // ========================================================
  // start sequence: reset pulse arms, release starts
  always @*
  begin
    armed_next = armed_reg;
    if (power_down)
    begin
      armed_next = 1'h0;
    end
    else if (conv_reset)
    begin
      armed_next = 1'h1;
    end
  end

  assign running = armed_reg && !conv_reset && !power_down;

  // ========================================================
  // conversion cycle timer
  // rate with filter mode
  assign period = conv_period(CONV_BASE[15:0],
                              conv_control_0_reg[`C0_RATE_HI:`C0_RATE_LO],
                              conv_control_1_reg[`C1_FILT_HI:`C1_FILT_LO]);

  assign conv_end = running && (cnt_reg == (period - 16'h0001));

  always @*
  begin
    cnt_next = cnt_reg;
    if (!running || conv_end)
    begin
      cnt_next = 16'h0000;
    end
    else
    begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  // ========================================================
  // result latch with hold
  always @*
  begin
    result_next = result_reg;
    if (conv_end && !conv_control_1_reg[`C1_HOLD])
    begin
      // full scale is two to the 23
      result_next = sat_code;
    end
  end

  // ========================================================
  // done and request flags; a completion wins over a clear
  always @*
  begin
    done_next = done_reg;
    req_next  = req_reg;
    if (wr_c1 && !WDATA[`C1_DONE])
    begin
      done_next = 1'h0;
    end
    if (wr_c1 && !WDATA[`C1_REQ])
    begin
      req_next = 1'h0;
    end
    if (conv_end)
    begin
      done_next = 1'h1;
      req_next  = 1'h1;
    end
  end

  // ========================================================
  // state flip-flops
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      armed_reg  <= 1'h0;
      cnt_reg    <= 16'h0000;
      result_reg <= `RST_RESULT;
      done_reg   <= 1'h0;
      req_reg    <= 1'h0;
    end
    else
    begin
      armed_reg  <= armed_next;
      cnt_reg    <= cnt_next;
      result_reg <= result_next;
      done_reg   <= done_next;
      req_reg    <= req_next;
    end
  end

  // ========================================================
  // read mux, data valid the cycle after the strobe
  always @*
  begin
    rdata_next = 8'h00;
    case (ADDR)
      `OFF_POWER_CONTROL:  rdata_next = power_control_reg;
      `OFF_CONV_CONTROL_0: rdata_next = conv_control_0_reg;
      `OFF_CONV_CONTROL_1:
      begin
        rdata_next = conv_control_1_reg;
        rdata_next[`C1_DONE] = done_reg;
        rdata_next[`C1_REQ]  = req_reg;
      end
      `OFF_AMP_CONTROL_0:  rdata_next = amp_control_0_reg;
      `OFF_AMP_CONTROL_1:  rdata_next = amp_control_1_reg;
      `OFF_AMP_CHANNEL:    rdata_next = amp_channel_reg;
      `OFF_RESULT_LOW:     rdata_next = result_reg[7:0];
      `OFF_RESULT_MIDDLE:  rdata_next = result_reg[15:8];
      `OFF_RESULT_HIGH:    rdata_next = result_reg[23:16];
      default:             rdata_next = 8'h00;
    endcase
  end

  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      RDATA <= 8'h00;
    end
    else if (RD)
    begin
      RDATA <= rdata_next;
    end
    else
    begin
      RDATA <= 8'h00;
    end
  end

  // ========================================================
  // regulator and common mode stay under power control
  // regulator and common mode
  assign REG_EN       = power_control_reg[`PC_REG_EN];
  assign REG_BYPASS   = power_control_reg[`PC_REG_BYPASS];
  assign REG_VOUT_SEL = power_control_reg[`PC_VOUT_SEL];
  assign VCM_EN       = power_control_reg[`PC_VCM_EN];

  // ========================================================
  // converter enables, all gated by power-down
  // power-down gates all
  assign AMP_EN       = !power_down;
  assign CONV_EN      = !power_down;
  assign FILTER_EN    = !power_down;
  assign FILTER_CLEAR = conv_reset && !power_down;
  assign FILTER_MODE  = conv_control_1_reg[`C1_FILT_HI:`C1_FILT_LO];

  assign REF_EXT_SEL  = conv_control_0_reg[`C0_REF_SEL];

  // ========================================================
  // gain and input routing to the front end
  // independent gain fields
  assign AMP_GAIN     = amp_control_0_reg[`A0_AMP_HI:`A0_AMP_LO];
  assign CONV_GAIN    = amp_control_0_reg[`A0_CONV_HI:`A0_CONV_LO];
  assign REF_GAIN     = amp_control_0_reg[`A0_REF_HI:`A0_REF_LO];
  assign OFFSET_TRIM  = amp_control_1_reg[`A1_TRIM_HI:`A1_TRIM_LO];
  assign AMP_POS_SEL  = amp_channel_reg[`CH_POS_HI:`CH_POS_LO];
  assign AMP_NEG_SEL  = amp_channel_reg[`CH_NEG_HI:`CH_NEG_LO];

  // sensor powered when either amplifier input selects it
  // temperature sensor routing
  assign pos_temp      = (AMP_POS_SEL == `CH_TEMP_POS);
  assign neg_temp      = (AMP_NEG_SEL == `CH_TEMP_NEG);
  assign TEMP_SENSE_EN = (pos_temp || neg_temp) && !power_down;

  // reference buffers
  assign POS_REF_BUF_EN = amp_control_1_reg[`A1_POS_BUF] && !power_down;
  assign NEG_REF_BUF_EN = amp_control_1_reg[`A1_NEG_BUF] && !power_down;

  // ========================================================
  // flag outputs
  assign CONV_DONE = done_reg;
  assign CONV_IRQ  = req_reg && conv_control_1_reg[`C1_INT_EN];

endmodule // sdadc_ctrl

// [sim/sdadc_fe_model.sv]
/*
  Analog front end model: presents the filter sample to the control block.
  Assumes the bench sets the applied input level on LEVEL.
*/
module sdadc_fe_model
#(
  parameter logic [31:0] TEMP_CODE = 32'h00001234
)
(
  input  wire logic        CLK,
  input  wire logic        CONV_EN,
  input  wire logic        TEMP_SENSE_EN,
  input  wire logic [31:0] LEVEL,
  output logic      [31:0] FE_SAMPLE
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [31:0] idle_pat = 32'h5a5a5a5a;

  // ======================================
  // unpowered output toggles every cycle
  always @(posedge CLK)
    idle_pat <= ~idle_pat;

  always_comb
    if (!CONV_EN)
      FE_SAMPLE = idle_pat;
    else if (TEMP_SENSE_EN)
      FE_SAMPLE = TEMP_CODE;
    else
      FE_SAMPLE = LEVEL;
endmodule // sdadc_fe_model

// [sim/sdadc_ctrl_props.sv]
/*
  Port checker for the converter control block.
  Assumes it is bound to every instance of sdadc_ctrl.
*/
`include "sdadc_regs.vh"
module sdadc_ctrl_props
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       AMP_EN,
  input wire logic       CONV_EN,
  input wire logic       FILTER_EN,
  input wire logic       FILTER_CLEAR,
  input wire logic [2:0] FILTER_MODE,
  input wire logic       REF_EXT_SEL,
  input wire logic [2:0] AMP_GAIN,
  input wire logic [1:0] CONV_GAIN,
  input wire logic [1:0] REF_GAIN,
  input wire logic [2:0] AMP_POS_SEL,
  input wire logic [2:0] AMP_NEG_SEL,
  input wire logic       TEMP_SENSE_EN,
  input wire logic       POS_REF_BUF_EN,
  input wire logic       NEG_REF_BUF_EN,
  input wire logic       REG_EN,
  input wire logic       REG_BYPASS,
  input wire logic       REG_VOUT_SEL,
  input wire logic       VCM_EN,
  input wire logic       CONV_DONE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // ======================================
  // assertions
  AST_PD_OFF: assert property (
    !CONV_EN |-> !AMP_EN && !FILTER_EN && !FILTER_CLEAR && !TEMP_SENSE_EN && !POS_REF_BUF_EN && !NEG_REF_BUF_EN)
    else $error("converter part on while powered down");
  AST_PD_WR: assert property (
    WR && ADDR == `OFF_CONV_CONTROL_0 |=> CONV_EN != $past(WDATA[7]))
    else $error("power-down bit not applied");
  AST_PD_NODONE: assert property (
    !CONV_DONE && !CONV_EN |=> !CONV_DONE)
    else $error("completion while powered down");
  AST_REF: assert property (
    WR && ADDR == `OFF_CONV_CONTROL_0 |=> REF_EXT_SEL == $past(WDATA[3]))
    else $error("reference select wrong");
  AST_GAIN: assert property (
    WR && ADDR == `OFF_AMP_CONTROL_0 |=> {REF_GAIN, CONV_GAIN, AMP_GAIN} == $past(WDATA[6:0]))
    else $error("gain fields wrong");
  AST_GAIN_KEEP: assert property (
    !(WR && ADDR == `OFF_AMP_CONTROL_0) |=> $stable({REF_GAIN, CONV_GAIN, AMP_GAIN}))
    else $error("gain changed without write");
  AST_POWER_CONTROL: assert property (
    WR && ADDR == `OFF_POWER_CONTROL && WDATA == 8'h83 |=> REG_EN && !REG_BYPASS && REG_VOUT_SEL && VCM_EN)
    else $error("power control pattern not applied");
  AST_FILT: assert property (
    WR && ADDR == `OFF_CONV_CONTROL_1 |=> FILTER_MODE == $past(WDATA[2:0]))
    else $error("filter mode wrong");
  AST_TEMP: assert property (
    CONV_EN && AMP_POS_SEL == `CH_TEMP_POS && AMP_NEG_SEL == `CH_TEMP_NEG |-> TEMP_SENSE_EN)
    else $error("sensor not enabled");
  AST_DONE_KEEP: assert property (
    CONV_DONE && !(WR && ADDR == `OFF_CONV_CONTROL_1) |=> CONV_DONE)
    else $error("done flag dropped");
  AST_RD_IDLE: assert property (
    !RD |=> RDATA == 8'h00)
    else $error("read data outside read cycle");

  // main scenarios
  CV_DONE: cover property ($rose(CONV_DONE));
  CV_HIGH: cover property (RD && ADDR == `OFF_RESULT_HIGH);
  CV_HOLD: cover property (WR && ADDR == `OFF_CONV_CONTROL_1 && WDATA[7]);
endmodule // sdadc_ctrl_props

bind sdadc_ctrl sdadc_ctrl_props sdadc_ctrl_props_i (.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .AMP_EN,
  .CONV_EN, .FILTER_EN, .FILTER_CLEAR, .FILTER_MODE, .REF_EXT_SEL, .AMP_GAIN, .CONV_GAIN, .REF_GAIN,
  .AMP_POS_SEL, .AMP_NEG_SEL, .TEMP_SENSE_EN, .POS_REF_BUF_EN, .NEG_REF_BUF_EN, .REG_EN, .REG_BYPASS,
  .REG_VOUT_SEL, .VCM_EN, .CONV_DONE);

// [sim/sdadc_ctrl_tb_top.sv]
/*
  Bench top: drives the register port and the front-end level.
  Assumes the checker binds itself to the design.
*/
`include "sdadc_regs.vh"
module sdadc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] BASE = 16'h0004;
  localparam logic [31:0] TEMP = 32'h00031234;
  logic CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
  logic [31:0] LEVEL = 32'h00000000, FE_SAMPLE;
  logic REG_EN, REG_BYPASS, REG_VOUT_SEL, VCM_EN, AMP_EN, CONV_EN, FILTER_EN, FILTER_CLEAR;
  logic REF_EXT_SEL, TEMP_SENSE_EN, POS_REF_BUF_EN, NEG_REF_BUF_EN, CONV_DONE, CONV_IRQ;
  logic [2:0] FILTER_MODE, AMP_GAIN, AMP_POS_SEL, AMP_NEG_SEL;
  logic [1:0] CONV_GAIN, REF_GAIN;
  logic [5:0] OFFSET_TRIM;
  int n_mismatch = 0, checks_done = 0, n;

  sdadc_ctrl #(.CONV_BASE(BASE)) sdadc_ctrl_i (.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .FE_SAMPLE,
    .REG_EN, .REG_BYPASS, .REG_VOUT_SEL, .VCM_EN, .AMP_EN, .CONV_EN, .FILTER_EN, .FILTER_CLEAR,
    .FILTER_MODE, .REF_EXT_SEL, .AMP_GAIN, .CONV_GAIN, .REF_GAIN, .OFFSET_TRIM, .AMP_POS_SEL,
    .AMP_NEG_SEL, .TEMP_SENSE_EN, .POS_REF_BUF_EN, .NEG_REF_BUF_EN, .CONV_DONE, .CONV_IRQ);
  sdadc_fe_model #(.TEMP_CODE(TEMP)) sdadc_fe_model_i (.CLK, .CONV_EN, .TEMP_SENSE_EN, .LEVEL, .FE_SAMPLE);

  // ======================================
  // clock, 100 ns period
  initial
    forever #50 CLK = ~CLK;

  // ======================================
  // bus and check tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // count edges until the done flag shows
  task automatic wait_done(output int c);
    c = 0;
    while (CONV_DONE !== 1'b1)
    begin
      @(posedge CLK);
      #1;
      c++;
      if (c > 3000)
      begin
        n_mismatch++;
        $display("[ERR] %0t no completion", $time);
        print_verdict;
      end
    end
  endtask
  // reset pulse, flags cleared while held, then run
  task automatic start(input logic [7:0] c0, input logic [7:0] c1, output int c);
    wr(`OFF_CONV_CONTROL_0, c0 | 8'h20);
    chk(FILTER_CLEAR, 1'b1);
    wr(`OFF_CONV_CONTROL_1, c1);
    wr(`OFF_CONV_CONTROL_0, c0);
    wait_done(c);
  endtask
  // next result under hold, bytes low to high
  task automatic conv_chk(input logic [31:0] lv, input logic [23:0] exp);
    logic [7:0] l, m, h;
    LEVEL <= lv;
    wr(`OFF_CONV_CONTROL_1, 8'h00);
    wait_done(n);
    wr(`OFF_CONV_CONTROL_1, 8'h80);
    rd(`OFF_RESULT_LOW, l);
    rd(`OFF_RESULT_MIDDLE, m);
    rd(`OFF_RESULT_HIGH, h);
    chk({h, m, l}, exp);
  endtask

  // ======================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    for (int a = 0; a < 10; a++)
      rdchk(a[7:0], (a == 1) ? 8'h80 : 8'h00);
    wr(`OFF_POWER_CONTROL, 8'h83);
    chk({REG_EN, REG_BYPASS, REG_VOUT_SEL, VCM_EN}, 4'b1011);
    wr(`OFF_AMP_CONTROL_0, 8'h6b);
    chk({REF_GAIN, CONV_GAIN, AMP_GAIN}, 7'h6b);
    wr(`OFF_AMP_CONTROL_0, 8'h00);
    wr(`OFF_AMP_CONTROL_1, 8'hc5);
    wr(`OFF_AMP_CHANNEL, 8'h3e);
    chk({TEMP_SENSE_EN, POS_REF_BUF_EN, NEG_REF_BUF_EN}, 3'b000);
    chk({AMP_NEG_SEL, AMP_POS_SEL, OFFSET_TRIM}, 12'hf85);
    wr(`OFF_AMP_CONTROL_1, 8'h00);
    wr(`OFF_AMP_CHANNEL, 8'h00);
    chk({REF_GAIN, CONV_GAIN, AMP_GAIN, OFFSET_TRIM, POS_REF_BUF_EN}, 14'h0000);
    wr(`OFF_CONV_CONTROL_0, 8'h09);
    chk({CONV_EN, AMP_EN, REF_EXT_SEL}, 3'b111);
    repeat (24) @(posedge CLK);
    chk(CONV_DONE, 1'b0);
    for (int r = 0; r < 8; r++)
    begin
      start(8'h08 | r[7:0], 8'h00, n);
      chk(n, BASE << r);
    end
    for (int f = 1; f < 8; f++)
    begin
      start(8'h08, f[7:0], n);
      chk({FILTER_MODE, n[15:0]}, {f[2:0], BASE << 1});
    end
    start(8'h09, 8'h00, n);
    conv_chk(32'h00012345, 24'h012345);
    conv_chk(32'hffffffff, 24'hffffff);
    conv_chk(32'h007fffff, 24'h7fffff);
    conv_chk(32'h01000000, 24'h7fffff);
    conv_chk(32'hff800000, 24'h800000);
    conv_chk(32'hf0000000, 24'h800000);
    LEVEL <= 32'h00000777;
    wr(`OFF_CONV_CONTROL_1, 8'h80);
    wait_done(n);
    rdchk(`OFF_RESULT_HIGH, 8'h80);
    conv_chk(32'h00000777, 24'h000777);
    start(8'h0f, 8'h20, n);
    repeat (20) @(posedge CLK);
    chk({CONV_DONE, CONV_IRQ}, 2'b11);
    rdchk(`OFF_CONV_CONTROL_1, 8'h70);
    wr(`OFF_CONV_CONTROL_1, 8'h20);
    chk({CONV_DONE, CONV_IRQ}, 2'b00);
    wait_done(n);
    chk(CONV_IRQ, 1'b1);
    wr(`OFF_AMP_CHANNEL, 8'h3e);
    chk(TEMP_SENSE_EN, 1'b1);
    wr(`OFF_AMP_CONTROL_1, 8'hc0);
    chk({POS_REF_BUF_EN, NEG_REF_BUF_EN}, 2'h3);
    conv_chk(32'h00000001, TEMP[23:0]);
    wr(`OFF_CONV_CONTROL_0, 8'h80);
    wr(`OFF_CONV_CONTROL_1, 8'h00);
    chk({CONV_EN, FILTER_EN, TEMP_SENSE_EN}, 3'b000);
    chk({POS_REF_BUF_EN, NEG_REF_BUF_EN, AMP_EN}, 3'h0);
    repeat (600) @(posedge CLK);
    chk(CONV_DONE, 1'b0);
    print_verdict;
  end
endmodule // sdadc_ctrl_tb_top
